// >>> design/urx_bit_engine.sv
`timescale 1ns/10ps
`default_nettype none
module urx_bit_engine (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // configuration
  input  wire logic        rxEnable,
  input  wire logic        nineBitSel,
  input  wire logic [15:0] bitPeriod,
  // serial line
  input  wire logic        rxLine,
  // received character
  output logic             charDone,
  output logic [8:0]       charData,
  output logic             charFrameErr
);
  // ==========================================
  // state
  urx_pkg::urx_state_e state_reg;
  logic [15:0]         cnt_reg;
  logic [3:0]          bitIdx_reg;
  logic [8:0]          shift_reg;
  logic                rxPrev_reg;

  // last data bit index, eight or nine bits
  logic [3:0] lastIdx;
  assign lastIdx = nineBitSel ? 4'h8 : 4'h7;

  // line history for start edge detection
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxPrev_reg <= 1'b1;
    end else begin
      rxPrev_reg <= rxLine;
    end
  end

  // bit timing and shifting
  always_ff @(posedge clock) begin
    if (sys_rst || !rxEnable) begin
      state_reg    <= urx_pkg::RX_IDLE;
      cnt_reg      <= 16'h0000;
      bitIdx_reg   <= 4'h0;
      shift_reg    <= 9'h000;
      charDone     <= 1'b0;
      charData     <= 9'h000;
      charFrameErr <= 1'b0;
    end else begin
      charDone <= 1'b0;
      if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      unique case (state_reg)
        urx_pkg::RX_IDLE: begin
          if (rxPrev_reg && !rxLine) begin
            state_reg <= urx_pkg::RX_START;
            cnt_reg   <= bitPeriod >> 1;
          end
        end
        urx_pkg::RX_START: begin
          if (cnt_reg == 16'h0000) begin
            // glitch shorter than half a bit is dropped
            state_reg  <= rxLine ? urx_pkg::RX_IDLE : urx_pkg::RX_DATA;
            cnt_reg    <= bitPeriod - 16'h0001;
            bitIdx_reg <= 4'h0;
            shift_reg  <= 9'h000;
          end
        end
        urx_pkg::RX_DATA: begin
          if (cnt_reg == 16'h0000) begin
            shift_reg[bitIdx_reg] <= rxLine;
            cnt_reg               <= bitPeriod - 16'h0001;
            bitIdx_reg            <= bitIdx_reg + 4'h1;
            if (bitIdx_reg == lastIdx) begin
              state_reg <= urx_pkg::RX_STOP;
            end
          end
        end
        urx_pkg::RX_STOP: begin
          if (cnt_reg == 16'h0000) begin
            // a missing stop is flagged, reception carries on
            charDone     <= 1'b1;
            charData     <= shift_reg;
            charFrameErr <= !rxLine;
            state_reg    <= urx_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> design/urx_receiver.sv
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module urx_receiver (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        rxLine,
  // status and interrupt
  output logic             rx_pending_flag,
  output logic             irqOut
);
  // ==========================================
  // helpers
  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] off);
    isReg = (addr == off);
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = isReg(addr, urx_pkg::OFF_CTRL) || isReg(addr, urx_pkg::OFF_STATUS)
            || isReg(addr, urx_pkg::OFF_DATA) || isReg(addr, urx_pkg::OFF_BAUD)
            || isReg(addr, urx_pkg::OFF_IRQSTAT) || isReg(addr, urx_pkg::OFF_IRQCLR)
            || isReg(addr, urx_pkg::OFF_IRQEN) || isReg(addr, urx_pkg::OFF_IRQCTL);
  endfunction

  // ==========================================
  // registers
  logic [3:0]           ctrl_reg;
  logic [15:0]          baud_reg;
  logic [2:0]           irqCtl_reg;
  logic [1:0]           irqStat_reg;
  logic [1:0]           irqStat_next;
  logic [1:0]           irqEn_reg;
  logic                 overrun_reg;
  logic [31:0]          rdata_reg;
  logic                 rdOk_reg;
  logic [urx_pkg::ENT_W-1:0] fifoMem [urx_pkg::FIFO_DEPTH];
  logic                 wrPtr_reg;
  logic                 rdPtr_reg;
  logic [1:0]           fifoCount_reg;

  // control bit views
  logic serial_port_enable;
  logic continuous_receive_enable;
  logic nine_bit_receive_select;
  logic address_detect_enable;
  assign serial_port_enable        = ctrl_reg[urx_pkg::CTRL_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable = ctrl_reg[urx_pkg::CTRL_CONTINUOUS_RECEIVE_ENABLE];
  assign nine_bit_receive_select   = ctrl_reg[urx_pkg::CTRL_NINE];
  assign address_detect_enable     = ctrl_reg[urx_pkg::CTRL_ADDR];

  // ==========================================
  // apb access decode
  logic setupPh;
  logic accessPh;
  logic wrAcc;
  logic dataReadAcc;
  assign setupPh     = psel && !penable;
  assign accessPh    = psel && penable;
  assign wrAcc       = accessPh && pwrite && isMapped(paddr);
  assign dataReadAcc = accessPh && !pwrite && isReg(paddr, urx_pkg::OFF_DATA);

  // zero wait states, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = accessPh && !isMapped(paddr);
  assign prdata  = rdata_reg;

  // ==========================================
  // receive engine
  logic       charDone;
  logic [8:0] charData;
  logic       charFrameErr;

  urx_bit_engine uEngine (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .rxEnable     (serial_port_enable && continuous_receive_enable),
    .nineBitSel   (nine_bit_receive_select),
    .bitPeriod    (baud_reg),
    .rxLine       (rxLine),
    .charDone     (charDone),
    .charData     (charData),
    .charFrameErr (charFrameErr)
  );

  // ==========================================
  // fifo push and pop decisions
  logic addrMode;
  logic charAccept;
  logic popEn;
  logic fifoFull;
  logic pushEn;
  logic ovrEvent;
  logic portOn;

  assign portOn   = serial_port_enable && continuous_receive_enable;
  assign addrMode = address_detect_enable && nine_bit_receive_select;
  // non-address characters vanish silently in address mode
  assign charAccept = charDone && portOn && (!addrMode || charData[8]);
  // pop only when the setup phase saw an entry
  assign popEn    = dataReadAcc && rdOk_reg && serial_port_enable;
  assign fifoFull = (fifoCount_reg == urx_pkg::FIFO_FULL) && !popEn;
  assign pushEn   = charAccept && !fifoFull && !overrun_reg;
  assign ovrEvent = charAccept && fifoFull && !overrun_reg;

  // fifo storage, framing bit kept per entry
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fifoMem[0] <= '0;
      fifoMem[1] <= '0;
    end else if (pushEn) begin
      fifoMem[wrPtr_reg] <= {charFrameErr, charData};
    end
  end

  // fifo pointers and occupancy, flushed by port disable
  always_ff @(posedge clock) begin
    if (sys_rst || !serial_port_enable) begin
      wrPtr_reg     <= 1'b0;
      rdPtr_reg     <= 1'b0;
      fifoCount_reg <= 2'h0;
    end else begin
      if (pushEn) begin
        wrPtr_reg <= !wrPtr_reg;
      end
      if (popEn) begin
        rdPtr_reg <= !rdPtr_reg;
      end
      unique case ({pushEn, popEn})
        2'b10:   fifoCount_reg <= fifoCount_reg + 2'h1;
        2'b01:   fifoCount_reg <= fifoCount_reg - 2'h1;
        default: fifoCount_reg <= fifoCount_reg;
      endcase
    end
  end

  // head entry views
  logic [urx_pkg::ENT_W-1:0] headEnt;
  logic                      framing_error_status;
  logic                      received_ninth_bit;
  assign headEnt = fifoMem[rdPtr_reg];
  // each entry keeps its own error, so all-bad entries keep reading set
  assign framing_error_status = (fifoCount_reg != 2'h0) && headEnt[urx_pkg::ENT_FRAMING_ERROR_STATUS];
  assign received_ninth_bit   = (fifoCount_reg != 2'h0) && headEnt[8];

  // overrun flag, cleared by either enable dropping
  always_ff @(posedge clock) begin
    if (sys_rst || !serial_port_enable || !continuous_receive_enable) begin
      overrun_reg <= 1'b0;
    end else if (ovrEvent) begin
      overrun_reg <= 1'b1;
    end
  end

  // pending flag tracks port enable and occupancy only
  assign rx_pending_flag = serial_port_enable && (fifoCount_reg != 2'h0);

  // ==========================================
  // software registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg   <= urx_pkg::CTRL_RESET;
      baud_reg   <= urx_pkg::BAUD_RESET;
      irqCtl_reg <= urx_pkg::ICTL_RESET;
      irqEn_reg  <= urx_pkg::EV_RESET;
    end else if (wrAcc) begin
      if (isReg(paddr, urx_pkg::OFF_CTRL)) begin
        ctrl_reg <= pwdata[3:0];
      end
      if (isReg(paddr, urx_pkg::OFF_BAUD)) begin
        baud_reg <= pwdata[15:0];
      end
      if (isReg(paddr, urx_pkg::OFF_IRQCTL)) begin
        irqCtl_reg <= pwdata[2:0];
      end
      if (isReg(paddr, urx_pkg::OFF_IRQEN)) begin
        irqEn_reg <= pwdata[urx_pkg::EV_W-1:0];
      end
    end
  end

  // sticky events, a new event beats a clear in the same cycle
  logic [1:0] irqClr;
  logic [1:0] irqEvents;
  assign irqClr = (wrAcc && isReg(paddr, urx_pkg::OFF_IRQCLR)) ?
                  pwdata[urx_pkg::EV_W-1:0] : 2'h0;
  // framing errors are not an event
  assign irqEvents = {ovrEvent, pushEn};

  always_comb begin
    irqStat_next = (irqStat_reg & ~irqClr) | irqEvents;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqStat_reg <= urx_pkg::EV_RESET;
    end else begin
      irqStat_reg <= irqStat_next;
    end
  end

  // receive request through the three enables, plus masked sticky events
  logic rxIrqReq;
  assign rxIrqReq = rx_pending_flag && irqCtl_reg[urx_pkg::ICTL_RXIE]
                 && irqCtl_reg[urx_pkg::ICTL_PERIPHERAL_IRQ_ENABLE]
                 && irqCtl_reg[urx_pkg::ICTL_GIE];
  assign irqOut = rxIrqReq || (|(irqStat_reg & irqEn_reg));

  // ==========================================
  // read data captured in the setup phase
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[urx_pkg::STAT_FRAMING_ERROR_STATUS]  = framing_error_status;
    statusWord[urx_pkg::STAT_NINTH] = received_ninth_bit;
    statusWord[urx_pkg::STAT_OVR]   = overrun_reg;
    statusWord[urx_pkg::STAT_PEND]  = rx_pending_flag;
    statusWord[urx_pkg::STAT_CNT+1:urx_pkg::STAT_CNT] = fifoCount_reg;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
      rdOk_reg  <= 1'b0;
    end else if (setupPh) begin
      rdOk_reg  <= (fifoCount_reg != 2'h0);
      rdata_reg <= 32'h0000_0000;
      if (!pwrite) begin
        if (isReg(paddr, urx_pkg::OFF_CTRL)) begin
          rdata_reg <= {28'h000_0000, ctrl_reg};
        end
        if (isReg(paddr, urx_pkg::OFF_STATUS)) begin
          rdata_reg <= statusWord;
        end
        if (isReg(paddr, urx_pkg::OFF_DATA) && fifoCount_reg != 2'h0) begin
          rdata_reg <= {24'h00_0000, headEnt[7:0]};
        end
        if (isReg(paddr, urx_pkg::OFF_BAUD)) begin
          rdata_reg <= {16'h0000, baud_reg};
        end
        if (isReg(paddr, urx_pkg::OFF_IRQSTAT)) begin
          rdata_reg <= {30'h0000_0000, irqStat_reg};
        end
        if (isReg(paddr, urx_pkg::OFF_IRQEN)) begin
          rdata_reg <= {30'h0000_0000, irqEn_reg};
        end
        if (isReg(paddr, urx_pkg::OFF_IRQCTL)) begin
          rdata_reg <= {29'h0000_0000, irqCtl_reg};
        end
      end
    end
  end

  // ==========================================
  // assertions
  pend_rise_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pushEn && fifoCount_reg == 2'h0 && serial_port_enable) |=> rx_pending_flag)
    else $error("pending flag missing after first store");

  pend_indep_a: assert property (@(posedge clock) disable iff (sys_rst)
    (irqCtl_reg == 3'h0 && pushEn && serial_port_enable) |=> rx_pending_flag && !rxIrqReq)
    else $error("pending flag tied to enables");

  irq_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    (irqOut && (irqStat_reg & irqEn_reg) == 2'h0) |-> (irqCtl_reg == 3'h7 && rx_pending_flag))
    else $error("receive request without all enables");

  framing_error_status_next_a: assert property (@(posedge clock) disable iff (sys_rst)
    (popEn && !pushEn && fifoCount_reg == 2'h2)
      |=> framing_error_status == $past(fifoMem[!rdPtr_reg][urx_pkg::ENT_FRAMING_ERROR_STATUS]))
    else $error("framing status not from next entry");

  serial_port_enable_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    !serial_port_enable |=> (!framing_error_status && !overrun_reg && fifoCount_reg == 2'h0))
    else $error("port disable did not reset receive state");

  continuous_receive_enable_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
    (serial_port_enable && $past(serial_port_enable) && !continuous_receive_enable && !popEn)
      |=> $stable(framing_error_status))
    else $error("receive disable changed framing status");

  ovr_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    (charAccept && fifoCount_reg == 2'h2 && !popEn) |=> overrun_reg ##1 overrun_reg || !portOn)
    else $error("third character did not set overrun");

  ovr_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    overrun_reg |-> !pushEn)
    else $error("character stored during overrun");

  ovr_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!continuous_receive_enable || !serial_port_enable) |=> !overrun_reg)
    else $error("overrun survived enable clear");

  addr_filt_a: assert property (@(posedge clock) disable iff (sys_rst)
    (charDone && addrMode && !charData[8]) |=> $stable(fifoCount_reg) || $past(popEn))
    else $error("non-address character stored");

  empty_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    (dataReadAcc && !rdOk_reg && !pushEn)
      |=> ($stable(rdPtr_reg) && $stable(fifoCount_reg) && $stable(overrun_reg)))
    else $error("empty read disturbed fifo");
endmodule
`default_nettype wire

// >>> include/urx_pkg.sv
// Summary of operation
// - pending flag is high while port enabled and FIFO holds an unread character.
// - receive interrupt needs receive, peripheral and global enables all set.
// - pending flag follows FIFO occupancy whatever the interrupt enables say.
// - each stored character carries its own framing-error bit, set on missing stop.
// - framing status shows the oldest entry; a data read pops to the next.
// - a framing error never stops reception of later characters.
// - clearing port enable resets port and framing status; clearing receive enable does not.
// - a framing error alone raises no interrupt.
// - if every entry has a framing error, reads keep showing it set.
// - FIFO holds two; a third complete character sets the overrun flag.
// - during overrun, stored characters stay readable and nothing new is stored.
// - clearing receive enable or port enable clears the overrun flag.
// - nine-bit select shifts nine data bits per character instead of eight.
// - ninth bit of the oldest entry is shown in its own status bit.
// - address mode with nine bits stores only ninth-bit-set characters.
`default_nettype none
package urx_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_DATA    = 8'h08;
  localparam logic [7:0] OFF_BAUD    = 8'h0c;
  localparam logic [7:0] OFF_IRQSTAT = 8'h10;
  localparam logic [7:0] OFF_IRQCLR  = 8'h14;
  localparam logic [7:0] OFF_IRQEN   = 8'h18;
  localparam logic [7:0] OFF_IRQCTL  = 8'h1c;
  // ==========================================
  // control fields
  localparam int CTRL_SERIAL_PORT_ENABLE  = 0;
  localparam int CTRL_CONTINUOUS_RECEIVE_ENABLE  = 1;
  localparam int CTRL_NINE  = 2;
  localparam int CTRL_ADDR  = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // status fields
  localparam int STAT_FRAMING_ERROR_STATUS  = 0;
  localparam int STAT_NINTH = 1;
  localparam int STAT_OVR   = 2;
  localparam int STAT_PEND  = 3;
  localparam int STAT_CNT   = 4;
  // interrupt control fields
  localparam int ICTL_RXIE  = 0;
  localparam int ICTL_PERIPHERAL_IRQ_ENABLE  = 1;
  localparam int ICTL_GIE   = 2;
  localparam logic [2:0] ICTL_RESET = 3'h0;
  // sticky event bits
  localparam int EV_CHAR    = 0;
  localparam int EV_OVR     = 1;
  localparam int EV_W       = 2;
  localparam logic [1:0] EV_RESET = 2'h0;
  // ==========================================
  // fifo entry layout and sizes
  localparam int ENT_FRAMING_ERROR_STATUS   = 9;
  localparam int ENT_W      = 10;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  // bit timing: clock cycles per serial bit
  localparam logic [15:0] BAUD_RESET = 16'h0010;
  // ==========================================
  // receive engine states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } urx_state_e;
endpackage
`default_nettype wire

// >>> verification/urx_receiver_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module urx_receiver_tb_top;
  // ==========================================
  // bench signals
  logic        clock;
  logic        sysRst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxLine;
  logic        pendFlag;
  logic        irqOut;
  logic        txGo;
  logic        txNine;
  logic        txStop;
  logic        txBusy;
  logic [8:0]  txData;
  logic [31:0] expQ[$];
  int          badCount;
  int          nTests;

  // ==========================================
  // design and far-side transmitter
  urx_receiver DUT (
    .clock(clock), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxLine(rxLine), .rx_pending_flag(pendFlag), .irqOut(irqOut)
  );
  urx_serial_tx farTx (
    .clock(clock), .txGo(txGo), .txData(txData), .txNine(txNine), .txStop(txStop),
    .bitLen(urx_pkg::BAUD_RESET), .rxLine(rxLine), .txBusy(txBusy)
  );

  // clock generator, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ==========================================
  // compare and report helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic flag(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // apb master: setup, access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    flag(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  // one character from the far side, waits for the frame to end
  task automatic send(input logic [8:0] d, input logic stopOk);
    int n = 0;
    @(posedge clock);
    txData <= d;
    txStop <= stopOk;
    txGo <= 1'b1;
    @(posedge clock);
    txGo <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (txBusy !== 1'b0 && n < 4000);
  endtask

  // read monitor: oldest note against data of each finished read
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      check(prdata, expQ.pop_front());
    end
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    finalReport();
  end

  // ==========================================
  // main sequence
  initial begin
    logic [7:0] b;
    sysRst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    txGo = 1'b0;
    txNine = 1'b0;
    txStop = 1'b1;
    txData = 9'h000;
    badCount = 0;
    nTests = 0;
    void'($urandom(32'h2bf9c23e));
    repeat (2) @(posedge clock);
    sysRst <= 1'b0;
    // reset values and an unmapped write
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h10);
    rd(8'h1c, 32'h0);
    apb(1'b1, 8'h20, 32'hff, 1'b1);
    rd(8'h00, 32'h0);
    wr(8'h00, 32'h3);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h0);
    // random characters
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      send({1'b0, b}, 1'b1);
      @(negedge clock);
      flag(pendFlag, 1'b1);
      rd(8'h04, 32'h18);
      rd(8'h08, {24'h0, b});
      @(negedge clock);
      flag(pendFlag, 1'b0);
    end
    // interrupt gating, sticky raise, mask, clear
    send(9'h05a, 1'b1);
    for (int v = 0; v < 8; v++) begin
      wr(8'h1c, 32'(v));
      @(negedge clock);
      flag(irqOut, v == 7);
      flag(pendFlag, 1'b1);
    end
    wr(8'h1c, 32'h0);
    wr(8'h18, 32'h1);
    @(negedge clock);
    flag(irqOut, 1'b1);
    wr(8'h18, 32'h0);
    @(negedge clock);
    flag(irqOut, 1'b0);
    wr(8'h14, 32'h3);
    rd(8'h10, 32'h0);
    rd(8'h08, 32'h5a);
    // framing faults
    wr(8'h18, 32'h2);
    send(9'h011, 1'b0);
    send(9'h022, 1'b1);
    @(negedge clock);
    flag(irqOut, 1'b0);
    rd(8'h04, 32'h29);
    rd(8'h08, 32'h11);
    rd(8'h04, 32'h18);
    rd(8'h08, 32'h22);
    send(9'h033, 1'b0);
    send(9'h044, 1'b0);
    rd(8'h08, 32'h33);
    rd(8'h04, 32'h19);
    wr(8'h00, 32'h1);
    rd(8'h04, 32'h19);
    wr(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h3);
    // overrun
    for (int k = 1; k < 4; k++) send(9'(k), 1'b1);
    rd(8'h04, 32'h2c);
    @(negedge clock);
    flag(irqOut, 1'b1);
    send(9'h004, 1'b1);
    rd(8'h08, 32'h01);
    rd(8'h08, 32'h02);
    send(9'h005, 1'b1);
    rd(8'h04, 32'h04);
    wr(8'h00, 32'h1);
    rd(8'h04, 32'h0);
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h0);
    // nine-bit characters and address filtering
    wr(8'h00, 32'h7);
    txNine <= 1'b1;
    send(9'h1a5, 1'b1);
    rd(8'h04, 32'h1a);
    rd(8'h08, 32'ha5);
    send(9'h0c3, 1'b1);
    rd(8'h04, 32'h18);
    rd(8'h08, 32'hc3);
    wr(8'h00, 32'hf);
    send(9'h033, 1'b1);
    @(negedge clock);
    flag(pendFlag, 1'b0);
    send(9'h155, 1'b1);
    wr(8'h00, 32'h7);
    send(9'h077, 1'b1);
    rd(8'h04, 32'h2a);
    rd(8'h08, 32'h55);
    rd(8'h08, 32'h77);
    wr(8'h00, 32'hf);
    // baud write, then a reset in mid-run flushes a stored character
    send(9'h1ab, 1'b1);
    wr(8'h0c, 32'h1234);
    rd(8'h0c, 32'h1234);
    sysRst <= 1'b1;
    repeat (2) @(posedge clock);
    sysRst <= 1'b0;
    rd(8'h0c, 32'h10);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    @(negedge clock);
    flag(pendFlag, 1'b0);
    flag(irqOut, 1'b0);
    repeat (4) @(posedge clock);
    finalReport();
  end
endmodule
`default_nettype wire

// >>> verification/urx_serial_tx.sv
`timescale 1ns/10ps
`default_nettype none
module urx_serial_tx (
  // clock
  input  wire logic        clock,
  // character request
  input  wire logic        txGo,
  input  wire logic [8:0]  txData,
  input  wire logic        txNine,
  input  wire logic        txStop,
  input  wire logic [15:0] bitLen,
  // line and status
  output logic             rxLine,
  output logic             txBusy
);
  // ==========================================
  // idle line, then per request: start, data lsb first, stop, two idle bits
  initial begin
    rxLine = 1'b1;
    txBusy = 1'b0;
    forever begin
      @(posedge clock);
      if (txGo) begin
        txBusy <= 1'b1;
        rxLine <= 1'b0;
        repeat (bitLen) @(posedge clock);
        for (int i = 0; i < (txNine ? 9 : 8); i++) begin
          rxLine <= txData[i];
          repeat (bitLen) @(posedge clock);
        end
        rxLine <= txStop;  // low stop level forces a framing fault
        repeat (bitLen) @(posedge clock);
        rxLine <= 1'b1;
        repeat (2 * bitLen) @(posedge clock);
        txBusy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
